// File: logic/crf_flag_bit.sv
// one write-one-to-clear event flag with set priority and init hold
`timescale 1ns/1ns
module crf_flag_bit (
  input  wire logic mclk_in,
  input  wire logic nrst_in,
  input  wire logic set_in,
  input  wire logic cond_in,
  input  wire logic clr_in,
  input  wire logic init_in,
  output logic      flag_out
);
  logic flag_r;
  logic flag_nxt;

  // next value: init holds reset, set beats clear, clear only after condition ends
  always_comb begin
    flag_nxt = flag_r;
    if (init_in) begin
      flag_nxt = 1'b0;
    end else if (set_in) begin
      flag_nxt = 1'b1;
    end else if (clr_in && !cond_in) begin
      flag_nxt = 1'b0;
    end
  end

  // register
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag_out = flag_r;

  // a set request outside init leaves the flag high next cycle
  set_wins_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    set_in && !init_in |=> flag_r) else $error("flag lost a set event");
  // no clear while the condition stays active
  hold_cond_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    flag_r && cond_in && !init_in |=> flag_r) else $error("flag cleared early");
  // a clear with the condition gone and no set drops the flag next cycle
  clear_works_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    clr_in && !cond_in && !set_in |=> !flag_r) else $error("flag not cleared");
endmodule

// File: logic/crf_state_decode.sv
// error state decode and change sensitivity filter for one direction
`timescale 1ns/1ns
module crf_state_decode #(
  parameter bit IS_RX = 1'b0
) (
  input  wire logic [8:0] count_in,
  input  wire logic [8:0] tec_in,
  input  wire logic [1:0] held_in,
  input  wire logic [1:0] sens_in,
  output logic      [1:0] state_out,
  output logic            change_out
);
  // counter to state code, bus-off taken from transmit counter
  always_comb begin
    if (tec_in > crf_pkg::OFF_LIMIT) begin
      state_out = crf_pkg::ST_OFF;
    end else if (count_in <= crf_pkg::WARN_LIMIT) begin
      state_out = crf_pkg::ST_OK;
    end else if (count_in <= crf_pkg::ERR_LIMIT) begin
      state_out = crf_pkg::ST_WRN;
    end else if (IS_RX || count_in <= crf_pkg::OFF_LIMIT) begin
      state_out = crf_pkg::ST_ERR;
    end else begin
      state_out = crf_pkg::ST_OFF;
    end
  end

  // decide whether the change is reportable at this sensitivity
  always_comb begin
    logic enter_off;
    logic enter_err;
    enter_off = (state_out == crf_pkg::ST_OFF) != (held_in == crf_pkg::ST_OFF);
    enter_err = (state_out[1]) != (held_in[1]);
    case (sens_in)
      crf_pkg::SENS_NONE: change_out = 1'b0;
      crf_pkg::SENS_OFF:  change_out = enter_off;
      crf_pkg::SENS_ERR:  change_out = enter_off | enter_err;
      crf_pkg::SENS_ALL:  change_out = state_out != held_in;
      default:            change_out = 1'b0;
    endcase
  end
endmodule

// File: logic/crf_top.sv
// receive flag and status block with axi4-lite register slave
// Functional notes
// - writing one clears flag, zero ignored
// - clear only after setting condition ends
// - state fields in 5:4, 3:2 read-only
// - init mode holds flags reset, ignores enable writes
// - state fields keep running during init
// - wake flag sets on sleep activity, enabled
// - change flag sets on bus status change
// - state fields frozen while change flag pending
// - receiver state encodes by receive counter
// - transmitter state encodes by transmit counter
// - bus-off shown in receiver, exits to ok
// - overrun sets flag, raises error request
// - receive-full sets on good message shift
// - set receive-full blocks next buffer shift
// - enabled flags raise wake, error, receive requests
// - sensitivity selects which changes set change flag
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
module crf_top (
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  // axi4-lite slave
  input  wire logic [4:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [4:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // receiver core events
  input  wire logic        init_acknowledge_in,
  input  wire logic        bus_activity_in,
  input  wire logic        overrun_event_in,
  input  wire logic        overrun_cond_in,
  input  wire logic        fifo_entry_valid_in,
  input  wire logic [8:0]  transmit_error_counter_in,
  input  wire logic [8:0]  receive_error_counter_in,
  // outputs
  output logic             init_request_out,
  output logic             sleep_request_out,
  output logic             buffer_shift_out,
  output logic             wake_irq_out,
  output logic             error_irq_out,
  output logic             receive_irq_out,
  output logic             irq_out
);
  // register bus state
  logic [4:0]  awaddr_r, awaddr_nxt;
  logic        aw_held_r, aw_held_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic        w_byte0_r, w_byte0_nxt;
  logic        w_held_r, w_held_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  // control state
  logic [7:0]  enable_r, enable_nxt;
  logic [2:0]  ctrl_r, ctrl_nxt;
  logic [3:0]  status_r, status_nxt;
  logic [3:0]  mask_r, mask_nxt;
  logic [3:0]  held_state_r, held_state_nxt;
  logic        init_mode;
  logic        wr_fire;
  logic        wr_flags;
  logic [7:0]  clr_bits;
  logic        rd_fire;
  // flag outputs and decode
  logic        wake_event_flag, bus_status_change_flag;
  logic        overrun_event_flag, receive_full_flag;
  logic [1:0]  rx_live, tx_live;
  logic        rx_change, tx_change;
  logic        change_set;
  logic        shift_now;
  logic [7:0]  flags_view;
  logic [3:0]  events;

  assign init_mode = ctrl_r[crf_pkg::CTRL_INIT_REQUEST_BIT] & init_acknowledge_in;

  // write channel accept, response after both address and data
  assign s_axi_awready_out = !aw_held_r && !bvalid_r;
  assign s_axi_wready_out  = !w_held_r && !bvalid_r;
  assign wr_fire  = aw_held_r && w_held_r && !bvalid_r;
  assign wr_flags = wr_fire && awaddr_r == crf_pkg::REG_FLAGS_OFS && w_byte0_r;
  assign clr_bits = wr_flags ? wdata_r[7:0] : 8'h00;

  always_comb begin
    awaddr_nxt  = awaddr_r;
    aw_held_nxt = aw_held_r;
    wdata_nxt   = wdata_r;
    w_byte0_nxt = w_byte0_r;
    w_held_nxt  = w_held_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      awaddr_nxt  = s_axi_awaddr_in;
      aw_held_nxt = 1'b1;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      wdata_nxt   = s_axi_wdata_in;
      w_byte0_nxt = s_axi_wstrb_in[0];
      w_held_nxt  = 1'b1;
    end
    if (wr_fire) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      case (awaddr_r)
        crf_pkg::REG_FLAGS_OFS, crf_pkg::REG_ENABLE_OFS, crf_pkg::REG_CTRL_OFS,
        crf_pkg::REG_IRQ_OFS, crf_pkg::REG_MASK_OFS: bresp_nxt = crf_pkg::RESP_OKAY;
        default: bresp_nxt = crf_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid_r && s_axi_bready_in) begin
      bvalid_nxt = 1'b0;
    end
  end

  // software writable registers: enables, control, mask
  always_comb begin
    enable_nxt = enable_r;
    ctrl_nxt   = ctrl_r;
    mask_nxt   = mask_r;
    if (wr_fire && w_byte0_r) begin
      case (awaddr_r)
        crf_pkg::REG_ENABLE_OFS: enable_nxt = wdata_r[7:0];
        crf_pkg::REG_CTRL_OFS:   ctrl_nxt   = wdata_r[2:0];
        crf_pkg::REG_MASK_OFS:   mask_nxt   = wdata_r[3:0];
        default:                 ctrl_nxt   = ctrl_r;
      endcase
    end
    if (init_mode) begin
      enable_nxt = crf_pkg::ENABLE_RESET;  // enables held reset in init mode
    end
  end

  // error state decode per direction
  crf_state_decode #(.IS_RX(1'b1)) u_rx_dec (
    .count_in   (receive_error_counter_in),
    .tec_in     (transmit_error_counter_in),
    .held_in    (held_state_r[3:2]),
    .sens_in    (enable_r[5:4]),
    .state_out  (rx_live),
    .change_out (rx_change)
  );
  crf_state_decode #(.IS_RX(1'b0)) u_tx_dec (
    .count_in   (transmit_error_counter_in),
    .tec_in     (transmit_error_counter_in),
    .held_in    (held_state_r[1:0]),
    .sens_in    (enable_r[3:2]),
    .state_out  (tx_live),
    .change_out (tx_change)
  );

  assign change_set = (rx_change | tx_change) && !bus_status_change_flag;

  // state fields follow counters unless change flag pending, init does not touch them
  always_comb begin
    held_state_nxt = held_state_r;
    if (!bus_status_change_flag) begin
      held_state_nxt = {rx_live, tx_live};
    end
  end

  // event flags
  crf_flag_bit u_wake (
    .mclk_in  (mclk_in),
    .nrst_in  (nrst_in),
    .set_in   (bus_activity_in && ctrl_r[crf_pkg::CTRL_SLEEP_BIT]
               && ctrl_r[crf_pkg::CTRL_WAKEEN_BIT]),
    .cond_in  (1'b0),
    .clr_in   (clr_bits[crf_pkg::WAKE_BIT]),
    .init_in  (init_mode),
    .flag_out (wake_event_flag)
  );
  crf_flag_bit u_change (
    .mclk_in  (mclk_in),
    .nrst_in  (nrst_in),
    .set_in   (change_set),
    .cond_in  (1'b0),
    .clr_in   (clr_bits[crf_pkg::CHANGE_BIT]),
    .init_in  (init_mode),
    .flag_out (bus_status_change_flag)
  );
  crf_flag_bit u_ovr (
    .mclk_in  (mclk_in),
    .nrst_in  (nrst_in),
    .set_in   (overrun_event_in),
    .cond_in  (overrun_cond_in),
    .clr_in   (clr_bits[crf_pkg::OVR_BIT]),
    .init_in  (init_mode),
    .flag_out (overrun_event_flag)
  );
  crf_flag_bit u_rxf (
    .mclk_in  (mclk_in),
    .nrst_in  (nrst_in),
    .set_in   (shift_now),
    .cond_in  (1'b0),
    .clr_in   (clr_bits[crf_pkg::RXF_BIT]),
    .init_in  (init_mode),
    .flag_out (receive_full_flag)
  );

  // shift next good fifo entry only when the foreground buffer is free
  assign shift_now = fifo_entry_valid_in && !receive_full_flag && !init_mode;
  assign buffer_shift_out = shift_now;

  assign flags_view = {wake_event_flag, bus_status_change_flag, held_state_r,
                       overrun_event_flag, receive_full_flag};

  // interrupt requests, flag and enable
  assign wake_irq_out    = wake_event_flag & enable_r[crf_pkg::WAKE_BIT];
  assign error_irq_out   = (bus_status_change_flag & enable_r[crf_pkg::CHANGE_BIT])
                         | (overrun_event_flag & enable_r[crf_pkg::OVR_BIT]);
  assign receive_irq_out = receive_full_flag & enable_r[crf_pkg::RXF_BIT];

  // sticky event status, cleared by read
  assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;
  assign events = {wake_irq_out, error_irq_out, receive_irq_out, shift_now};
  always_comb begin
    status_nxt = status_r;
    if (rd_fire && s_axi_araddr_in == crf_pkg::REG_IRQ_OFS) begin
      status_nxt = crf_pkg::IRQ_RESET;
    end
    status_nxt = status_nxt | events;  // new events win over the read clear
  end
  assign irq_out = |(status_r & mask_r);

  // read channel
  assign s_axi_arready_out = !rvalid_r;
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = crf_pkg::RESP_OKAY;
      case (s_axi_araddr_in)
        crf_pkg::REG_FLAGS_OFS:  rdata_nxt = {24'h000000, flags_view};
        crf_pkg::REG_ENABLE_OFS: rdata_nxt = {24'h000000, enable_r};
        crf_pkg::REG_CTRL_OFS:   rdata_nxt = {23'h000000, init_acknowledge_in, 5'h00, ctrl_r};
        crf_pkg::REG_IRQ_OFS:    rdata_nxt = {28'h0000000, status_r};
        crf_pkg::REG_MASK_OFS:   rdata_nxt = {28'h0000000, mask_r};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = crf_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready_in) begin
      rvalid_nxt = 1'b0;
    end
  end

  // register all state
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      awaddr_r     <= 5'h00;
      aw_held_r    <= 1'b0;
      wdata_r      <= 32'h00000000;
      w_byte0_r    <= 1'b0;
      w_held_r     <= 1'b0;
      bvalid_r     <= 1'b0;
      bresp_r      <= crf_pkg::RESP_OKAY;
      rvalid_r     <= 1'b0;
      rdata_r      <= 32'h00000000;
      rresp_r      <= crf_pkg::RESP_OKAY;
      enable_r     <= crf_pkg::ENABLE_RESET;
      ctrl_r       <= crf_pkg::CTRL_RESET;
      status_r     <= crf_pkg::IRQ_RESET;
      mask_r       <= crf_pkg::IRQ_RESET;
      held_state_r <= 4'h0;
    end else begin
      awaddr_r     <= awaddr_nxt;
      aw_held_r    <= aw_held_nxt;
      wdata_r      <= wdata_nxt;
      w_byte0_r    <= w_byte0_nxt;
      w_held_r     <= w_held_nxt;
      bvalid_r     <= bvalid_nxt;
      bresp_r      <= bresp_nxt;
      rvalid_r     <= rvalid_nxt;
      rdata_r      <= rdata_nxt;
      rresp_r      <= rresp_nxt;
      enable_r     <= enable_nxt;
      ctrl_r       <= ctrl_nxt;
      status_r     <= status_nxt;
      mask_r       <= mask_nxt;
      held_state_r <= held_state_nxt;
    end
  end

  assign s_axi_bvalid_out  = bvalid_r;
  assign s_axi_bresp_out   = bresp_r;
  assign s_axi_rvalid_out  = rvalid_r;
  assign s_axi_rdata_out   = rdata_r;
  assign s_axi_rresp_out   = rresp_r;
  assign init_request_out  = ctrl_r[crf_pkg::CTRL_INIT_REQUEST_BIT];
  assign sleep_request_out = ctrl_r[crf_pkg::CTRL_SLEEP_BIT];

  // init mode keeps every event flag at zero
  init_hold_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    init_mode |=> (flags_view[7:6] == 2'h0 && flags_view[1:0] == 2'h0)
    || !$past(init_mode)) else $error("flag set during init");
  // state frozen while change flag pending
  state_frozen_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    bus_status_change_flag |=> $stable(held_state_r)) else $error("state moved");
  // a full foreground buffer blocks the shift
  shift_block_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    receive_full_flag |-> !buffer_shift_out) else $error("shift while full");
  // shift sets receive-full next cycle
  rxf_set_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    buffer_shift_out |=> receive_full_flag) else $error("full flag not set");
  // bus-off in transmit counter shows in both fields once unfrozen
  bus_off_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    transmit_error_counter_in > 9'h0ff && !bus_status_change_flag
    |=> held_state_r == 4'hf) else $error("bus-off not shown");
  // reportable change raises the change flag
  change_set_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    change_set && !init_mode |=> bus_status_change_flag) else $error("no change flag");
  // receive request follows flag and enable
  rx_req_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    receive_irq_out == (receive_full_flag && enable_r[0])) else $error("rx request");
  // write to state field bits leaves them alone
  ro_state_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    wr_flags && bus_status_change_flag && !change_set
    |=> $stable(held_state_r)) else $error("state written");
endmodule

// File: shared/crf_pkg.sv
// package of register map, field layout and state codes for the receive flag block
package crf_pkg;
  // register byte offsets on the register bus
  localparam logic [4:0] REG_FLAGS_OFS  = 5'h00;  // receive_flag_status
  localparam logic [4:0] REG_ENABLE_OFS = 5'h04;  // receive_irq_enable_reg
  localparam logic [4:0] REG_CTRL_OFS   = 5'h08;  // control: init, wake enable, sleep
  localparam logic [4:0] REG_IRQ_OFS    = 5'h0c;  // sticky events, read clears
  localparam logic [4:0] REG_MASK_OFS   = 5'h10;  // event mask
  // flag register field positions
  localparam int WAKE_BIT   = 7;
  localparam int CHANGE_BIT = 6;
  localparam int RECEIVER_ERROR_STATE_LSB  = 4;
  localparam int TRANSMITTER_ERROR_STATE_LSB  = 2;
  localparam int OVR_BIT    = 1;
  localparam int RXF_BIT    = 0;
  // control register field positions
  localparam int CTRL_INIT_REQUEST_BIT = 0;
  localparam int CTRL_WAKEEN_BIT = 1;
  localparam int CTRL_SLEEP_BIT  = 2;
  localparam int CTRL_INIT_ACKNOWLEDGE_BIT = 8;
  // reset values
  localparam logic [7:0] FLAGS_RESET  = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [2:0] CTRL_RESET   = 3'h0;
  localparam logic [3:0] IRQ_RESET    = 4'h0;
  // error counter thresholds
  localparam logic [8:0] WARN_LIMIT = 9'h060;   // 96
  localparam logic [8:0] ERR_LIMIT  = 9'h07f;   // 127
  localparam logic [8:0] OFF_LIMIT  = 9'h0ff;   // 255
  // two-bit error state codes
  localparam logic [1:0] ST_OK  = 2'h0;
  localparam logic [1:0] ST_WRN = 2'h1;
  localparam logic [1:0] ST_ERR = 2'h2;
  localparam logic [1:0] ST_OFF = 2'h3;
  // sensitivity codes
  localparam logic [1:0] SENS_NONE = 2'h0;
  localparam logic [1:0] SENS_OFF  = 2'h1;
  localparam logic [1:0] SENS_ERR  = 2'h2;
  localparam logic [1:0] SENS_ALL  = 2'h3;
  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: tb/crf_can_node_model.sv
// behavioural receiver core and bus side feeding the flag block
`timescale 1ns/1ns
module crf_can_node_model (
  input  wire logic       mclk_in,
  input  wire logic       nrst_in,
  input  wire logic       buffer_shift_in,
  input  wire logic       init_request_in,
  output logic            init_acknowledge_out,
  output logic            bus_activity_out,
  output logic            overrun_event_out,
  output logic            overrun_cond_out,
  output logic            fifo_entry_valid_out,
  output logic [8:0]      tec_out,
  output logic [8:0]      rec_out
);
  int   queued = 0;
  int   taken  = 0;
  logic ack_r  = 1'b0;

  // quiet levels from time zero
  initial begin
    {init_acknowledge_out, bus_activity_out, overrun_event_out} = 3'h0;
    {overrun_cond_out, tec_out, rec_out} = 19'h0;
  end

  // acknowledge trails the request by two edges, so init is never instant
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_r <= 1'b0;
      init_acknowledge_out <= 1'b0;
    end else begin
      ack_r <= init_request_in;
      init_acknowledge_out <= ack_r;
      if (buffer_shift_in && fifo_entry_valid_out) begin
        taken <= taken + 1;
      end
    end
  end

  // an entry waits until the block moves it into the foreground buffer
  assign fifo_entry_valid_out = queued > taken;

  // queues good frames in the receive fifo
  task automatic add_frames(input int n);
    @(posedge mclk_in);
    queued <= queued + n;
  endtask

  // sets the overrun condition and both error counters
  task automatic set_link(input logic c, input logic [8:0] t, input logic [8:0] r);
    @(posedge mclk_in);
    overrun_cond_out <= c;
    tec_out <= t;
    rec_out <= r;
  endtask

  // one-cycle bus activity or overrun event
  task automatic pulse(input logic wake);
    @(posedge mclk_in);
    bus_activity_out <= wake;
    overrun_event_out <= !wake;
    @(posedge mclk_in);
    bus_activity_out <= 1'b0;
    overrun_event_out <= 1'b0;
  endtask
endmodule

// File: tb/crf_top_tb.sv
// self-checking bench for the receive flag and status block
`timescale 1ns/1ns
module crf_top_tb;
  logic        mclk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [4:0]  awaddr  = 5'h00;
  logic [4:0]  araddr  = 5'h00;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'hf;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        init_ack, bus_act, ovr_evt, ovr_cond, fifo_valid;
  logic        init_req, sleep_req, shift, wake_irq, err_irq, rx_irq, irq;
  logic [8:0]  transmit_error_counter, receive_error_counter, t, r;
  logic [65:0] exp_q[$];
  logic [65:0] note;
  int          miscompares = 0;
  int          checked = 0;
  int          seed = 32'ha5b8;
  logic [4:0]  ofs [5] = '{crf_pkg::REG_FLAGS_OFS, crf_pkg::REG_ENABLE_OFS,
                           crf_pkg::REG_CTRL_OFS, crf_pkg::REG_IRQ_OFS, crf_pkg::REG_MASK_OFS};
  logic [8:0]  bnd [6] = '{9'h060, 9'h061, 9'h07f, 9'h080, 9'h0ff, 9'h100};

  // 50 MHz clock
  always #10 mclk_in = ~mclk_in;

  crf_top crf_top_i (
    .mclk_in(mclk_in), .nrst_in(nrst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .init_acknowledge_in(init_ack),
    .bus_activity_in(bus_act), .overrun_event_in(ovr_evt), .overrun_cond_in(ovr_cond),
    .fifo_entry_valid_in(fifo_valid), .transmit_error_counter_in(transmit_error_counter),
    .receive_error_counter_in(receive_error_counter), .init_request_out(init_req),
    .sleep_request_out(sleep_req), .buffer_shift_out(shift), .wake_irq_out(wake_irq),
    .error_irq_out(err_irq), .receive_irq_out(rx_irq), .irq_out(irq)
  );

  crf_can_node_model crf_can_node_model_i (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .buffer_shift_in(shift),
    .init_request_in(init_req), .init_acknowledge_out(init_ack),
    .bus_activity_out(bus_act), .overrun_event_out(ovr_evt), .overrun_cond_out(ovr_cond),
    .fifo_entry_valid_out(fifo_valid), .tec_out(transmit_error_counter), .rec_out(receive_error_counter)
  );

  // prints the counts and the verdict, then stops
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // counts and reports one mismatch
  task automatic fail(input string msg);
    miscompares++;
    $display("Error at %0t: %s", $time, msg);
  endtask

  // compares a level output at this edge
  task automatic chk(input logic got, input logic exp);
    checked++;
    if (got !== exp) fail("level output mismatch");
  endtask

  // one write, address and data offered together; response noted in the queue
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    int n = 0;
    bit done = 0;
    exp_q.push_back({crf_pkg::RESP_OKAY, 64'h0});
    @(posedge mclk_in);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge mclk_in);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1;
        bready <= 1'b0;
      end
    end
    if (!done) begin
      fail("write timeout");
      complete_run();
    end
  endtask

  // one read; expected data under mask and response noted in the queue
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] rs = crf_pkg::RESP_OKAY);
    int n = 0;
    bit done = 0;
    exp_q.push_back({rs, m, e & m});
    @(posedge mclk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge mclk_in);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1;
        rready <= 1'b0;
      end
    end
    if (!done) begin
      fail("read timeout");
      complete_run();
    end
  endtask

  // flag register shorthands and counter setting
  task automatic rf(input logic [7:0] e);
    rd(ofs[0], {24'h0, e}, 32'hff);
  endtask
  task automatic link(input logic c, input logic [8:0] tc, input logic [8:0] rc);
    crf_can_node_model_i.set_link(c, tc, rc);
    repeat (2) @(posedge mclk_in);
  endtask

  // bounded wait for the init acknowledge level
  task automatic wait_ack(input logic v);
    int n = 0;
    while (init_ack !== v && n < 50) begin
      @(posedge mclk_in);
      n++;
    end
    if (init_ack !== v) begin
      fail("init handshake timeout");
      complete_run();
    end
  endtask

  // expected receiver and transmitter state from the counters
  function automatic logic [3:0] st(input logic [8:0] tc, input logic [8:0] rc);
    logic [1:0] rs, ts;
    ts = tc > 9'h0ff ? 2'h3 : tc > 9'h07f ? 2'h2 : tc > 9'h060 ? 2'h1 : 2'h0;
    rs = tc > 9'h0ff ? 2'h3 : rc > 9'h07f ? 2'h2 : rc > 9'h060 ? 2'h1 : 2'h0;
    return {rs, ts};
  endfunction

  // takes the oldest note whenever a response is handed over
  always @(posedge mclk_in) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      checked++;
      note = exp_q.pop_front();
      if ((bvalid ? {bresp, 32'h0} : {rresp, rdata & note[63:32]})
          !== {note[65:64], note[31:0]}) fail("bus response mismatch");
    end
  end

  // main sequence
  initial begin
    repeat (8) @(posedge mclk_in);
    nrst_in <= 1'b1;
    rf(8'h00);
    rd(ofs[1], 32'h0, 32'hff);
    rd(ofs[2], 32'h0, 32'h107);
    rd(5'h14, 32'h0, 32'hffffffff, crf_pkg::RESP_SLVERR);
    // state decode at the boundaries, then random counts
    for (int i = 0; i < 14; i++) begin
      t = (i < 6) ? bnd[i] : 9'($random(seed));
      r = (i < 6) ? bnd[5 - i] : 9'($random(seed));
      link(1'b0, t, r);
      rf({2'h0, st(t, r), 2'h0});
    end
    wr(ofs[0], 32'h3c);
    rf({2'h0, st(t, r), 2'h0});
    // overrun with a lasting condition, error request and sticky status
    rd(ofs[3], 32'h0, 32'h0);
    wr(ofs[4], 32'h4);
    wr(ofs[1], 32'h2);
    link(1'b1, 9'h000, 9'h000);
    crf_can_node_model_i.pulse(1'b0);
    rf(8'h02);
    chk(err_irq, 1'b1);
    chk(irq, 1'b1);
    wr(ofs[0], 32'h02);
    rf(8'h02);
    link(1'b0, 9'h000, 9'h000);
    wr(ofs[0], 32'hfd);
    rf(8'h02);
    wr(ofs[0], 32'h02, 4'he);
    rf(8'h02);
    wr(ofs[0], 32'h02);
    rf(8'h00);
    chk(err_irq, 1'b0);
    rd(ofs[3], 32'h4, 32'h4);
    @(posedge mclk_in);
    chk(irq, 1'b0);
    // a full foreground buffer holds the next fifo entry back
    wr(ofs[1], 32'h1);
    crf_can_node_model_i.add_frames(2);
    repeat (4) @(posedge mclk_in);
    rf(8'h01);
    chk(rx_irq, 1'b1);
    chk(fifo_valid, 1'b1);
    wr(ofs[0], 32'h01);
    repeat (2) @(posedge mclk_in);
    rf(8'h01);
    chk(fifo_valid, 1'b0);
    wr(ofs[0], 32'h01);
    rf(8'h00);
    chk(rx_irq, 1'b0);
    // wake flag needs sleep and the wake enable together
    wr(ofs[1], 32'h80);
    wr(ofs[2], 32'h4);
    crf_can_node_model_i.pulse(1'b1);
    rf(8'h00);
    wr(ofs[2], 32'h6);
    rd(ofs[2], 32'h6, 32'h107);
    chk(sleep_req, 1'b1);
    crf_can_node_model_i.pulse(1'b1);
    rf(8'h80);
    chk(wake_irq, 1'b1);
    wr(ofs[0], 32'h80);
    wr(ofs[2], 32'h0);
    // change flag with bus-off sensitivity, frozen states and release
    wr(ofs[1], 32'h44);
    link(1'b0, 9'h064, 9'h000);
    rf(8'h04);
    link(1'b0, 9'h12c, 9'h000);
    rf(8'h7c);
    chk(err_irq, 1'b1);
    link(1'b0, 9'h000, 9'h000);
    rf(8'h7c);
    wr(ofs[0], 32'h40);
    repeat (2) @(posedge mclk_in);
    rf(8'h40);
    wr(ofs[0], 32'h40);
    rf(8'h00);
    // init mode holds flags and enables but not the states
    wr(ofs[1], 32'h2);
    link(1'b1, 9'h000, 9'h000);
    crf_can_node_model_i.pulse(1'b0);
    wr(ofs[2], 32'h1);
    wait_ack(1'b1);
    chk(init_req, 1'b1);
    rd(ofs[2], 32'h101, 32'h107);
    rf(8'h00);
    wr(ofs[1], 32'h2);
    rd(ofs[1], 32'h0, 32'hff);
    link(1'b0, 9'h12c, 9'h000);
    rf(8'h3c);
    link(1'b0, 9'h000, 9'h000);
    wr(ofs[2], 32'h0);
    wait_ack(1'b0);
    crf_can_node_model_i.pulse(1'b0);
    rf(8'h02);
    wr(ofs[0], 32'h02);
    rf(8'h00);
    complete_run();
  end
endmodule
